// file: logic/wdg_defines.vh
// Purpose: Constants shared by the supervision timer files.
// Assumes: Oscillator counts are in cycles of the 32768 Hz crystal clock.
// Notes:   Register offsets are byte addresses on the plain register port.
`ifndef WDG_DEFINES_VH
`define WDG_DEFINES_VH

`define WDG_AW           8
`define WDG_DW           32
`define WDG_CNT_W        16
`define WDG_HOLD_W       13
`define WDG_SYNC_W       5
`define WDG_IRQ_W        2

`define WDG_OSC_HZ       32768
`define WDG_PERIOD_MS    1500
// Sized so that each count meets its 16-bit or 13-bit target without truncation.
// 1.5 s of crystal ticks.
`define WDG_TERM_CNT     16'hC000
`define WDG_EW_US        1000
// About 1 ms of crystal ticks.
`define WDG_EW_CNT       16'h0021
// 4100 crystal cycles.
`define WDG_HOLD_CYC     13'h1004
`define WDG_HOLD_MS      125
`define WDG_START_ADDR   16'h0000

`define WDG_REG_CTRL     8'h00
`define WDG_REG_STATUS   8'h04
`define WDG_REG_IRQ_STAT 8'h08
`define WDG_REG_IRQ_MASK 8'h0C
`define WDG_REG_COUNT    8'h10

`define WDG_CTRL_REFRESH 0
`define WDG_CTRL_EWEN    1
`define WDG_CTRL_CLRFLAG 2

`define WDG_ST_FLAG      0
`define WDG_ST_RUN       1
`define WDG_ST_HOLD      2
`define WDG_ST_DBG       3
`define WDG_ST_STRAP     4

`define WDG_IRQ_EW       0
`define WDG_IRQ_OVF      1

`define WDG_SY_OSC       0
`define WDG_SY_RSTPIN    1
`define WDG_SY_WAKE      2
`define WDG_SY_DBG       3
`define WDG_SY_STRAP     4

`endif

// file: logic/wdg_sync2.v
// Purpose: Two-stage synchroniser for the pin-level inputs.
// Assumes: Each bit is an independent level.
// Notes:   Only the second stage leaves this module.
`timescale 1ns/1ps
`default_nettype none
`include "wdg_defines.vh"

module wdg_sync2 (
  input  wire                   clk_in,
  input  wire                   sys_rst_in,
  input  wire [`WDG_SYNC_W-1:0] async_in,
  output reg  [`WDG_SYNC_W-1:0] sync_out
);

  reg [`WDG_SYNC_W-1:0] meta;

  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      meta     <= {`WDG_SYNC_W{1'b0}};
      sync_out <= {`WDG_SYNC_W{1'b0}};
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule // wdg_sync2
`default_nettype wire

// file: logic/wdg_irq.v
// Purpose: Sticky interrupt status, mask and level interrupt output.
// Assumes: A read of the status register clears every bit.
// Notes:   A new event in the clearing cycle stays set.
`timescale 1ns/1ps
`default_nettype none
`include "wdg_defines.vh"

module wdg_irq (
  input  wire                  clk_in,
  input  wire                  sys_rst_in,
  input  wire [`WDG_IRQ_W-1:0] event_in,
  input  wire                  stat_rd_in,
  input  wire                  mask_wr_in,
  input  wire [`WDG_IRQ_W-1:0] mask_data_in,
  output reg  [`WDG_IRQ_W-1:0] stat_out,
  output reg  [`WDG_IRQ_W-1:0] mask_out,
  output wire                  irq_out
);

  wire [`WDG_IRQ_W-1:0] next_stat;

  assign next_stat = (stat_out & {`WDG_IRQ_W{~stat_rd_in}}) | event_in;
  assign irq_out   = |(stat_out & mask_out);

  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      stat_out <= {`WDG_IRQ_W{1'b0}};
      mask_out <= {`WDG_IRQ_W{1'b0}};
    end else begin
      stat_out <= next_stat;
      if (mask_wr_in) begin
        mask_out <= mask_data_in;
      end
    end
  end

endmodule // wdg_irq
`default_nettype wire

// file: logic/wdg_timer.v
// Purpose: Fixed-period supervision timer with chip reset and restart.
// Assumes: clk_in is 10 MHz; the crystal clock arrives as a pin level.
// Notes:   Nothing software writes can stop the count.
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "wdg_defines.vh"

module wdg_timer #(
  parameter [`WDG_CNT_W-1:0]  TERM_CNT = `WDG_TERM_CNT,
  parameter [`WDG_HOLD_W-1:0] HOLD_CYC = `WDG_HOLD_CYC
) (
  input  wire              clk_in,
  input  wire              sys_rst_in,
  input  wire              osc_clk_in,
  input  wire              reset_pin_in,
  input  wire              wake_in,
  input  wire              debug_enable_in,
  input  wire              supervisory_voltage_strap_in,
  input  wire [`WDG_AW-1:0] addr_in,
  input  wire [`WDG_DW-1:0] wdata_in,
  input  wire              wr_in,
  input  wire              rd_in,
  output reg  [`WDG_DW-1:0] rdata_out,
  output reg               chip_reset_out,
  output reg               iram_wake_state_out,
  output reg               cpu_start_out,
  output reg  [15:0]       start_addr_out,
  output reg               fault_detect_en_out,
  output reg               overflow_sticky_flag_out,
  output wire              irq_out
);

  localparam ST_RUN  = 1'b0;
  localparam ST_HOLD = 1'b1;

  // Warning threshold sits the warning lead ahead of the overflow tick.
  localparam [`WDG_CNT_W-1:0] EW_LEAD = `WDG_EW_CNT;
  localparam [`WDG_CNT_W-1:0] TERM_M1 = TERM_CNT - 16'h0001;
  localparam [`WDG_CNT_W-1:0] EW_CNT  = TERM_M1 - EW_LEAD;
  localparam [`WDG_HOLD_W-1:0] HOLD_M1 = HOLD_CYC - 13'h0001;

  // Register decode shared by the read and write paths.
  function hit;
    input [`WDG_AW-1:0] a;
    input [`WDG_AW-1:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  wire [`WDG_SYNC_W-1:0] pins_raw;
  wire [`WDG_SYNC_W-1:0] pins_s;

  assign pins_raw[`WDG_SY_OSC]    = osc_clk_in;
  assign pins_raw[`WDG_SY_RSTPIN] = reset_pin_in;
  assign pins_raw[`WDG_SY_WAKE]   = wake_in;
  assign pins_raw[`WDG_SY_DBG]    = debug_enable_in;
  assign pins_raw[`WDG_SY_STRAP]  = supervisory_voltage_strap_in;

  wdg_sync2 u_sync (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .async_in   (pins_raw),
    .sync_out   (pins_s)
  );

  wire osc_s   = pins_s[`WDG_SY_OSC];
  wire rstpin  = pins_s[`WDG_SY_RSTPIN];
  wire wake_s  = pins_s[`WDG_SY_WAKE];
  wire dbg_s   = pins_s[`WDG_SY_DBG];
  wire strap_s = pins_s[`WDG_SY_STRAP];

  reg                    osc_q;
  reg                    state;
  reg  [`WDG_CNT_W-1:0]  count;
  reg  [`WDG_HOLD_W-1:0] hold_cnt;
  reg                    ew_enable;
  reg                    ew_done;

  reg                    next_state;
  reg  [`WDG_CNT_W-1:0]  next_count;
  reg  [`WDG_HOLD_W-1:0] next_hold_cnt;
  reg                    next_ew_done;
  reg                    ovf_evt;
  reg                    ew_evt;
  reg                    start_evt;

  wire tick = osc_s & ~osc_q;

  wire wr_ctrl  = wr_in & hit(addr_in, `WDG_REG_CTRL);
  wire wr_mask  = wr_in & hit(addr_in, `WDG_REG_IRQ_MASK);
  wire rd_istat = rd_in & hit(addr_in, `WDG_REG_IRQ_STAT);

  wire refresh  = wr_ctrl & wdata_in[`WDG_CTRL_REFRESH];
  wire clr_flag = wr_ctrl & wdata_in[`WDG_CTRL_CLRFLAG];

  wire disabled = strap_s | dbg_s;

  wire [`WDG_IRQ_W-1:0] irq_evt;
  wire [`WDG_IRQ_W-1:0] irq_stat;
  wire [`WDG_IRQ_W-1:0] irq_mask;

  assign irq_evt[`WDG_IRQ_EW]  = ew_evt;
  assign irq_evt[`WDG_IRQ_OVF] = ovf_evt;

  wdg_irq u_irq (
    .clk_in       (clk_in),
    .sys_rst_in   (sys_rst_in),
    .event_in     (irq_evt),
    .stat_rd_in   (rd_istat),
    .mask_wr_in   (wr_mask),
    .mask_data_in (wdata_in[`WDG_IRQ_W-1:0]),
    .stat_out     (irq_stat),
    .mask_out     (irq_mask),
    .irq_out      (irq_out)
  );

  // Next-state logic for the count and the reset hold sequence.
  always @* begin
    next_state    = state;
    next_count    = count;
    next_hold_cnt = hold_cnt;
    next_ew_done  = ew_done;
    ovf_evt       = 1'b0;
    ew_evt        = 1'b0;
    start_evt     = 1'b0;
    case (state)
      ST_RUN: begin
        if (disabled || !wake_s) begin
          next_count   = {`WDG_CNT_W{1'b0}};
          next_ew_done = 1'b0;
        end else if (refresh) begin
          next_count   = {`WDG_CNT_W{1'b0}};
          next_ew_done = 1'b0;
        end else if (tick) begin
          if (count == TERM_M1) begin
            ovf_evt       = 1'b1;
            next_state    = ST_HOLD;
            next_count    = {`WDG_CNT_W{1'b0}};
            next_hold_cnt = {`WDG_HOLD_W{1'b0}};
            next_ew_done  = 1'b0;
          end else begin
            next_count = count + 16'h0001;
            if (count == EW_CNT && ew_enable && !ew_done) begin
              ew_evt       = 1'b1;
              next_ew_done = 1'b1;
            end
          end
        end
      end
      ST_HOLD: begin
        if (tick) begin
          if (hold_cnt == HOLD_M1) begin
            next_state    = ST_RUN;
            next_hold_cnt = {`WDG_HOLD_W{1'b0}};
            start_evt     = 1'b1;
          end else begin
            next_hold_cnt = hold_cnt + 13'h0001;
          end
        end
      end
      default: begin
        next_state    = ST_RUN;
        next_count    = {`WDG_CNT_W{1'b0}};
        next_hold_cnt = {`WDG_HOLD_W{1'b0}};
        next_ew_done  = 1'b0;
      end
    endcase
  end

  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      osc_q    <= 1'b0;
      state    <= ST_RUN;
      count    <= {`WDG_CNT_W{1'b0}};
      hold_cnt <= {`WDG_HOLD_W{1'b0}};
      ew_done  <= 1'b0;
    end else begin
      osc_q    <= osc_s;
      state    <= next_state;
      count    <= next_count;
      hold_cnt <= next_hold_cnt;
      ew_done  <= next_ew_done;
    end
  end

  // Early-warning enable survives the chip reset; only software changes it.
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ew_enable <= 1'b0;
    end else if (wr_ctrl) begin
      ew_enable <= wdata_in[`WDG_CTRL_EWEN];
    end
  end

  // Chip reset and restart outputs.
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      chip_reset_out      <= 1'b0;
      iram_wake_state_out <= 1'b0;
      cpu_start_out       <= 1'b0;
      start_addr_out      <= `WDG_START_ADDR;
      fault_detect_en_out <= 1'b1;
    end else begin
      chip_reset_out      <= (next_state == ST_HOLD);
      iram_wake_state_out <= (next_state == ST_HOLD);
      cpu_start_out       <= start_evt;
      start_addr_out      <= `WDG_START_ADDR;
      fault_detect_en_out <= ~strap_s;
    end
  end

  // The sticky flag is not touched by the chip reset this block drives.
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      overflow_sticky_flag_out <= 1'b0;
    end else if (ovf_evt) begin
      overflow_sticky_flag_out <= 1'b1;
    end else if (rstpin) begin
      overflow_sticky_flag_out <= 1'b0;
    end else if (clr_flag) begin
      overflow_sticky_flag_out <= 1'b0;
    end
  end

  // Read data stand only in the cycle after the read strobe.
  reg [`WDG_DW-1:0] next_rdata;

  always @* begin
    next_rdata = {`WDG_DW{1'b0}};
    if (rd_in) begin
      case (addr_in)
        `WDG_REG_CTRL: begin
          next_rdata[`WDG_CTRL_EWEN] = ew_enable;
        end
        `WDG_REG_STATUS: begin
          next_rdata[`WDG_ST_FLAG]  = overflow_sticky_flag_out;
          next_rdata[`WDG_ST_RUN]   = ~disabled & wake_s;
          next_rdata[`WDG_ST_HOLD]  = state;
          next_rdata[`WDG_ST_DBG]   = dbg_s;
          next_rdata[`WDG_ST_STRAP] = strap_s;
        end
        `WDG_REG_IRQ_STAT: begin
          next_rdata[`WDG_IRQ_W-1:0] = irq_stat;
        end
        `WDG_REG_IRQ_MASK: begin
          next_rdata[`WDG_IRQ_W-1:0] = irq_mask;
        end
        `WDG_REG_COUNT: begin
          next_rdata[`WDG_CNT_W-1:0] = count;
        end
        default: begin
          next_rdata = {`WDG_DW{1'b0}};
        end
      endcase
    end
  end

  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdata_out <= {`WDG_DW{1'b0}};
    end else begin
      rdata_out <= next_rdata;
    end
  end

endmodule // wdg_timer
`default_nettype wire

// file: test/wdg_timer_props.sv
// Purpose: Port-level assertions for the supervision timer.
// Assumes: One clock domain; pins pass two sync stages.
// Notes:   Bound into every wdg_timer instance.
`timescale 1ns/1ps
`default_nettype none
module wdg_timer_chk #(
  parameter TERM_CNT = 64,
  parameter HOLD_CYC = 5
) (
  input wire        clk_in,
  input wire        sys_rst_in,
  input wire        reset_pin_in,
  input wire        wake_in,
  input wire        debug_enable_in,
  input wire        supervisory_voltage_strap_in,
  input wire [7:0]  addr_in,
  input wire        wr_in,
  input wire        rd_in,
  input wire [31:0] rdata_out,
  input wire        chip_reset_out,
  input wire        iram_wake_state_out,
  input wire        cpu_start_out,
  input wire [15:0] start_addr_out,
  input wire        fault_detect_en_out,
  input wire        overflow_sticky_flag_out,
  input wire        irq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  chk_iram_follows: assert property (iram_wake_state_out == chip_reset_out)
    else $error("io ram state differs");
  chk_start_addr: assert property (start_addr_out == 16'h0000)
    else $error("start address not zero");
  chk_start_pulse: assert property (cpu_start_out |-> $fell(chip_reset_out) ##1 !cpu_start_out)
    else $error("start pulse misplaced");
  chk_hold_len: assert property ($rose(chip_reset_out) |=> chip_reset_out[*8])
    else $error("hold too short");
  chk_flag_set: assert property ($rose(chip_reset_out) |-> overflow_sticky_flag_out)
    else $error("flag not set on overflow");
  chk_flag_clear: assert property ($fell(overflow_sticky_flag_out) |->
      $past(wr_in) || $past(reset_pin_in, 3) || $past(reset_pin_in, 4))
    else $error("flag fell without cause");
  chk_pin_clears: assert property ((reset_pin_in && !chip_reset_out)[*5] |-> !overflow_sticky_flag_out)
    else $error("pin did not clear flag");
  chk_strap_fault: assert property ($stable(supervisory_voltage_strap_in)[*5] |->
      fault_detect_en_out == !supervisory_voltage_strap_in)
    else $error("fault detect wrong");
  chk_debug_stops: assert property (debug_enable_in[*8] |-> !$rose(chip_reset_out))
    else $error("overflow under debug");
  chk_wake_holds: assert property ((!wake_in)[*8] |-> !$rose(chip_reset_out))
    else $error("overflow with wake low");
  chk_unmapped_rd: assert property (rd_in && addr_in == 8'hFC |=> rdata_out == 32'h0)
    else $error("unmapped read not zero");
  cov_overflow: cover property ($rose(chip_reset_out));
  cov_start: cover property (cpu_start_out);
  cov_irq: cover property ($rose(irq_out));
endmodule // wdg_timer_chk
bind wdg_timer wdg_timer_chk #(.TERM_CNT(TERM_CNT), .HOLD_CYC(HOLD_CYC)) i_wdg_timer_chk (
  .clk_in, .sys_rst_in, .reset_pin_in, .wake_in, .debug_enable_in,
  .supervisory_voltage_strap_in, .addr_in, .wr_in, .rd_in, .rdata_out,
  .chip_reset_out, .iram_wake_state_out, .cpu_start_out, .start_addr_out,
  .fault_detect_en_out, .overflow_sticky_flag_out, .irq_out);
`default_nettype wire

// file: test/fixed_period_watchdog_tb_top.sv
// Purpose: Self-checking bench for the supervision timer.
// Assumes: Crystal ticks every 8 clocks; shortened counts.
// Notes:   Reads queue expectations for a watching process.
`timescale 1ns/1ps
`default_nettype none
`include "wdg_defines.vh"
module fixed_period_watchdog_tb_top;
  localparam int TC = 64;
  localparam int HC = 5;
  localparam logic [2:0] HOLDS [3] = '{3'b101, 3'b011, 3'b000};
  logic        clk_in = 1'b0, sys_rst_in = 1'b1, osc = 1'b0, osc_on = 1'b0;
  logic        pin = 1'b0, dbg = 1'b0, strap = 1'b0, wake = 1'b1;
  logic        wr = 1'b0, rd = 1'b0, rd_seen = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [15:0] saddr;
  logic        chip_rst, iram, start, fde, flag, irq;
  logic [31:0] exp_q [$], msk_q [$];
  int          miscompares = 0, samples_checked = 0, cyc = 0, k;
  wdg_timer #(.TERM_CNT(16'(TC)), .HOLD_CYC(13'(HC))) i_wdg_timer (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .osc_clk_in(osc), .reset_pin_in(pin),
    .wake_in(wake), .debug_enable_in(dbg), .supervisory_voltage_strap_in(strap),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .chip_reset_out(chip_rst), .iram_wake_state_out(iram), .cpu_start_out(start),
    .start_addr_out(saddr), .fault_detect_en_out(fde),
    .overflow_sticky_flag_out(flag), .irq_out(irq));
  initial forever #50 clk_in = ~clk_in;
  task automatic end_sim;
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk_in);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    bus(1'b0, a, 32'h0);
  endtask
  // Sampled on the falling edge so the design's updates have landed.
  task automatic wait_hi(ref logic s, input int n);
    k = 0;
    while (s !== 1'b1 && k < n) begin
      @(negedge clk_in);
      k++;
    end
    check("wait", 32'(s), 32'h1);
  endtask
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (osc_on && cyc % 4 == 0)
      osc <= ~osc;
    if (cyc == 10000) begin
      miscompares++;
      end_sim();
    end
  end
  always @(posedge clk_in) rd_seen <= rd;
  always @(negedge clk_in) begin
    if (rd_seen)
      check("rdata", rdata & msk_q.pop_front(), exp_q.pop_front());
  end
  initial begin
    k = $urandom(32'h589826AE);
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    check("fde", 32'(fde), 32'h1);
    rd_reg(8'hFC, 32'h0, 32'hFFFFFFFF);
    osc_on <= 1'b1;
    repeat (3) begin
      repeat (TC * 4) @(posedge clk_in);
      bus(1'b1, `WDG_REG_CTRL, 32'h1);
    end
    rd_reg(`WDG_REG_STATUS, 32'h0, 32'h1);
    osc_on <= 1'b0;
    k = $urandom % 4;
    bus(1'b1, `WDG_REG_IRQ_MASK, 32'(k));
    rd_reg(`WDG_REG_IRQ_MASK, 32'(k), 32'h3);
    bus(1'b1, `WDG_REG_IRQ_MASK, 32'h3);
    bus(1'b1, `WDG_REG_CTRL, 32'h3);
    rd_reg(`WDG_REG_COUNT, 32'h0, 32'hFFFF);
    osc_on <= 1'b1;
    wait_hi(irq, 600);
    check("warn", 32'(k > 236 && k < 258), 32'h1);
    rd_reg(`WDG_REG_IRQ_STAT, 32'h1, 32'h3);
    wait_hi(chip_rst, 300);
    check("period", 32'(k > 250 && k < 272), 32'h1);
    check("iram", 32'(iram), 32'h1);
    check("flag", 32'(flag), 32'h1);
    wait_hi(start, 60);
    check("hold", 32'(k), 32'(HC * 8));
    check("addr", 32'(saddr), 32'h0);
    check("rst", 32'(chip_rst), 32'h0);
    rd_reg(`WDG_REG_STATUS, 32'h1, 32'h1);
    rd_reg(`WDG_REG_IRQ_STAT, 32'h2, 32'h3);
    pin <= 1'b1;
    repeat (6) @(posedge clk_in);
    pin <= 1'b0;
    rd_reg(`WDG_REG_STATUS, 32'h0, 32'h1);
    bus(1'b1, `WDG_REG_IRQ_MASK, 32'h2);
    bus(1'b1, `WDG_REG_CTRL, 32'h1);
    wait_hi(irq, 600);
    check("noewarn", 32'(chip_rst), 32'h1);
    wait_hi(start, 60);
    bus(1'b1, `WDG_REG_CTRL, 32'h4);
    rd_reg(`WDG_REG_STATUS, 32'h0, 32'h1);
    rd_reg(`WDG_REG_IRQ_STAT, 32'h2, 32'h3);
    // The clearing read lands at this edge; look once it has settled.
    @(negedge clk_in);
    check("irq", 32'(irq), 32'h0);
    @(posedge clk_in);
    // Debug, then strap, then wake low: each must pin the count at zero.
    for (int i = 0; i < 3; i++) begin
      {dbg, strap, wake} <= HOLDS[i];
      repeat (TC * 10) @(posedge clk_in);
      rd_reg(`WDG_REG_COUNT, 32'h0, 32'hFFFF);
      rd_reg(`WDG_REG_STATUS, 32'h0, 32'h3);
      check("fde", 32'(fde), 32'(!HOLDS[i][1]));
    end
    end_sim();
  end
endmodule // fixed_period_watchdog_tb_top
`default_nettype wire
